// *** pkg/irq_flag_enable_map.svh ***
/*
 * Register offsets, field positions, reset values and widths
 * of the primary interrupt control block.
 * Assumes a 32-bit classic Wishbone slave with word-aligned registers.
 */
`ifndef IRQ_FLAG_ENABLE_MAP_SVH
`define IRQ_FLAG_ENABLE_MAP_SVH

// ============================================================
// Register byte offsets
`define CTRL_A_OFS      8'h00
`define CTRL_B_OFS      8'h04
`define CTRL_C_OFS      8'h08
`define CORE_STAT_OFS   8'h0c
`define EVT_STAT_OFS    8'h10
`define EVT_MASK_OFS    8'h14

// ============================================================
// Field positions, control register a
`define A_MASTER_EN_BIT 0
`define A_EXT_EN_BIT    1
`define A_CIPHER_EN_BIT 2
`define A_TICK0_EN_BIT  3
`define A_EXT_FLAG_BIT  4
`define A_CIPHER_F_BIT  5
`define A_TICK0_F_BIT   6
`define A_IMPL_MASK     8'h7f

// ============================================================
// Field positions, control register b
`define B_TICK1_EN_BIT  0
`define B_GRP0_EN_BIT   1
`define B_GRP1_EN_BIT   2
`define B_LOWV_EN_BIT   3
`define B_TICK1_F_BIT   4
`define B_GRP0_F_BIT    5
`define B_GRP1_F_BIT    6
`define B_LOWV_F_BIT    7
`define B_IMPL_MASK     8'hff

// ============================================================
// Field positions, control register c
`define C_NVM_EN_BIT    0
`define C_NVM_F_BIT     4
`define C_IMPL_MASK     8'h11

// ============================================================
// Reset values and widths
`define CTRL_RESET      8'h00
`define NUM_SRC         8
`define EVT_BITS        3

`endif

// *** pkg/irq_flag_enable_pkg.sv ***
/*
 * Types shared by the interrupt control block.
 * Assumes the map header for numeric constants.
 */
package irq_flag_enable_pkg;

  // Classic Wishbone request from the master
  typedef struct packed {
    logic        cyc;
    logic        stb;
    logic        we;
    logic [7:0]  adr;
    logic [3:0]  sel;
    logic [31:0] dat;
  } wb_req_t;

  // Slave answer
  typedef struct packed {
    logic        ack;
    logic        err;
    logic [31:0] dat;
  } wb_rsp_t;

  // Vectored request towards the core
  typedef struct packed {
    logic       valid;
    logic [2:0] src;
  } irq_vec_t;

  typedef enum logic [0:0] {
    BUS_IDLE,
    BUS_ACK
  } bus_state_t;

endpackage

// *** rtl/irq_event_sync.sv ***
/*
 * Two-flop synchroniser for a bank of event levels with rise detect.
 * Assumes asynchronous or foreign-domain level inputs.
 */
`timescale 1ns/1ns
`default_nettype none

module irq_event_sync #(
  parameter int WIDTH = 8
) (
  // Clock and reset
  input  wire logic             clk_i,
  input  wire logic             rst_i,
  // Levels in, pulses out
  input  wire logic [WIDTH-1:0] level_i,
  output logic      [WIDTH-1:0] rise_o
);

  logic [WIDTH-1:0] meta_q;
  logic [WIDTH-1:0] sync_q;
  logic [WIDTH-1:0] last_q;
  logic [WIDTH-1:0] meta_d;
  logic [WIDTH-1:0] sync_d;
  logic [WIDTH-1:0] last_d;

  always_comb begin
    meta_d = level_i;
    sync_d = meta_q;
    last_d = sync_q;
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      meta_q <= '0;
      sync_q <= '0;
      last_q <= '0;
    end else begin
      meta_q <= meta_d;
      sync_q <= sync_d;
      last_q <= last_d;
    end
  end

  // One pulse per rising level
  genvar g;
  generate
    for (g = 0; g < WIDTH; g = g + 1) begin : g_rise
      assign rise_o[g] = sync_q[g] & ~last_q[g];
    end
  endgenerate

endmodule
`default_nettype wire

// *** rtl/irq_flag_enable_regs.sv ***
/*
 * Primary interrupt flag and enable registers with vector request,
 * core handshake, wake output and a sticky event status with mask.
 * Assumes a classic Wishbone master on clk_i and event levels from
 * other domains, which pass irq_event_sync before use.
 */
`timescale 1ns/1ns
`default_nettype none
`include "irq_flag_enable_map.svh"

module irq_flag_enable_regs
  import irq_flag_enable_pkg::*;
(
  // Clock and reset
  input  wire logic                        clk_i,
  input  wire logic                        rst_i,
  // Wishbone slave
  input  wire irq_flag_enable_pkg::wb_req_t wb_req_i,
  output irq_flag_enable_pkg::wb_rsp_t      wb_rsp_o,
  // Event levels: tick0, cipher, ext, tick1, grp0, grp1, lowv, nvm
  input  wire logic [7:0]                  event_i,
  // Core side
  input  wire logic                        stack_full_i,
  input  wire logic                        vec_ack_i,
  output irq_flag_enable_pkg::irq_vec_t     vec_o,
  output logic                             wake_o,
  output logic                             irq_o
);
  import irq_flag_enable_pkg::*;

  localparam int NSRC = `NUM_SRC;

  // ============================================================
  // Event synchroniser
  logic [NSRC-1:0] evt_rise;

  irq_event_sync #(
    .WIDTH (NSRC)
  ) u_sync (
    .clk_i   (clk_i),
    .rst_i   (rst_i),
    .level_i (event_i),
    .rise_o  (evt_rise)
  );

  // ============================================================
  // Bus decode
  bus_state_t  bus_q;
  bus_state_t  bus_d;
  logic        ack_q;
  logic        ack_d;
  logic        err_q;
  logic        err_d;
  logic [31:0] rdat_q;
  logic [31:0] rdat_d;
  logic        req;
  logic        wr_take;
  logic        hit_a;
  logic        hit_b;
  logic        hit_c;
  logic        hit_st;
  logic        hit_mk;
  logic        hit_cs;
  logic        mapped;
  logic [7:0]  wbyte;

  assign req    = wb_req_i.cyc & wb_req_i.stb & (bus_q == BUS_IDLE);
  assign hit_a  = wb_req_i.adr == `CTRL_A_OFS;
  assign hit_b  = wb_req_i.adr == `CTRL_B_OFS;
  assign hit_c  = wb_req_i.adr == `CTRL_C_OFS;
  assign hit_cs = wb_req_i.adr == `CORE_STAT_OFS;
  assign hit_st = wb_req_i.adr == `EVT_STAT_OFS;
  assign hit_mk = wb_req_i.adr == `EVT_MASK_OFS;
  assign mapped = hit_a | hit_b | hit_c | hit_cs | hit_st | hit_mk;
  assign wr_take = req & wb_req_i.we & wb_req_i.sel[0] & mapped;
  assign wbyte  = wb_req_i.dat[7:0];

  // ============================================================
  // Control registers
  logic [7:0] ctrl_a_q;
  logic [7:0] ctrl_a_d;
  logic [7:0] ctrl_b_q;
  logic [7:0] ctrl_b_d;
  logic [7:0] ctrl_c_q;
  logic [7:0] ctrl_c_d;
  logic [NSRC-1:0] flag_vec;
  logic [NSRC-1:0] en_vec;
  logic [NSRC-1:0] pend;
  logic [2:0]  sel_src;
  logic        any_pend;
  logic        take;

  // Per-source flag and enable views, in priority order
  assign flag_vec = {ctrl_c_q[`C_NVM_F_BIT],
                     ctrl_b_q[`B_LOWV_F_BIT],
                     ctrl_b_q[`B_GRP1_F_BIT],
                     ctrl_b_q[`B_GRP0_F_BIT],
                     ctrl_b_q[`B_TICK1_F_BIT],
                     ctrl_a_q[`A_EXT_FLAG_BIT],
                     ctrl_a_q[`A_CIPHER_F_BIT],
                     ctrl_a_q[`A_TICK0_F_BIT]};
  assign en_vec   = {ctrl_c_q[`C_NVM_EN_BIT],
                     ctrl_b_q[`B_LOWV_EN_BIT],
                     ctrl_b_q[`B_GRP1_EN_BIT],
                     ctrl_b_q[`B_GRP0_EN_BIT],
                     ctrl_b_q[`B_TICK1_EN_BIT],
                     ctrl_a_q[`A_EXT_EN_BIT],
                     ctrl_a_q[`A_CIPHER_EN_BIT],
                     ctrl_a_q[`A_TICK0_EN_BIT]};

  // Source and master enable both needed
  assign pend = flag_vec & en_vec
              & {NSRC{ctrl_a_q[`A_MASTER_EN_BIT]}};
  assign any_pend = |pend;

  // Lowest index wins
  always_comb begin
    sel_src = 3'h0;
    for (int i = NSRC - 1; i >= 0; i--) begin
      if (pend[i]) begin
        sel_src = 3'(i);
      end
    end
  end

  // Vector taken by the core only with room on the stack
  assign take = vec_ack_i & any_pend & ~stack_full_i;

  always_comb begin
    ctrl_a_d = ctrl_a_q;
    ctrl_b_d = ctrl_b_q;
    ctrl_c_d = ctrl_c_q;
    if (wr_take & hit_a) begin
      ctrl_a_d = wbyte & `A_IMPL_MASK;
    end
    if (wr_take & hit_b) begin
      ctrl_b_d = wbyte & `B_IMPL_MASK;
    end
    if (wr_take & hit_c) begin
      ctrl_c_d = wbyte & `C_IMPL_MASK;
    end
    // Service entry: flag cleared, nesting blocked
    if (take) begin
      ctrl_a_d[`A_MASTER_EN_BIT] = 1'b0;
      case (sel_src)
        3'h0: ctrl_a_d[`A_TICK0_F_BIT] = 1'b0;
        3'h1: ctrl_a_d[`A_CIPHER_F_BIT] = 1'b0;
        3'h2: ctrl_a_d[`A_EXT_FLAG_BIT] = 1'b0;
        3'h3: ctrl_b_d[`B_TICK1_F_BIT] = 1'b0;
        3'h4: ctrl_b_d[`B_GRP0_F_BIT] = 1'b0;
        3'h5: ctrl_b_d[`B_GRP1_F_BIT] = 1'b0;
        3'h6: ctrl_b_d[`B_LOWV_F_BIT] = 1'b0;
        default: ctrl_c_d[`C_NVM_F_BIT] = 1'b0;
      endcase
    end
    // Events set flags regardless of enables; set beats clear
    if (evt_rise[0]) begin
      ctrl_a_d[`A_TICK0_F_BIT] = 1'b1;
    end
    if (evt_rise[1]) begin
      ctrl_a_d[`A_CIPHER_F_BIT] = 1'b1;
    end
    if (evt_rise[2]) begin
      ctrl_a_d[`A_EXT_FLAG_BIT] = 1'b1;
    end
    if (evt_rise[3]) begin
      ctrl_b_d[`B_TICK1_F_BIT] = 1'b1;
    end
    if (evt_rise[4]) begin
      ctrl_b_d[`B_GRP0_F_BIT] = 1'b1;
    end
    if (evt_rise[5]) begin
      ctrl_b_d[`B_GRP1_F_BIT] = 1'b1;
    end
    if (evt_rise[6]) begin
      ctrl_b_d[`B_LOWV_F_BIT] = 1'b1;
    end
    if (evt_rise[7]) begin
      ctrl_c_d[`C_NVM_F_BIT] = 1'b1;
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ctrl_a_q <= `CTRL_RESET;
      ctrl_b_q <= `CTRL_RESET;
      ctrl_c_q <= `CTRL_RESET;
    end else begin
      ctrl_a_q <= ctrl_a_d;
      ctrl_b_q <= ctrl_b_d;
      ctrl_c_q <= ctrl_c_d;
    end
  end

  // ============================================================
  // Sticky event status and mask
  logic [NSRC-1:0] stat_q;
  logic [NSRC-1:0] stat_d;
  logic [NSRC-1:0] mask_q;
  logic [NSRC-1:0] mask_d;

  always_comb begin
    stat_d = stat_q;
    mask_d = mask_q;
    if (wr_take & hit_st) begin
      stat_d = stat_q & ~wbyte;
    end
    if (wr_take & hit_mk) begin
      mask_d = wbyte;
    end
    stat_d = stat_d | evt_rise;
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      stat_q <= '0;
      mask_q <= '0;
    end else begin
      stat_q <= stat_d;
      mask_q <= mask_d;
    end
  end

  // ============================================================
  // Bus answer
  always_comb begin
    bus_d  = BUS_IDLE;
    ack_d  = 1'b0;
    err_d  = 1'b0;
    rdat_d = rdat_q;
    case (bus_q)
      BUS_IDLE: begin
        if (req) begin
          bus_d  = BUS_ACK;
          ack_d  = mapped;
          err_d  = ~mapped;
          rdat_d = 32'h0000_0000;
          if (hit_a) begin
            rdat_d[7:0] = ctrl_a_q & `A_IMPL_MASK;
          end
          if (hit_b) begin
            rdat_d[7:0] = ctrl_b_q;
          end
          if (hit_c) begin
            rdat_d[7:0] = ctrl_c_q & `C_IMPL_MASK;
          end
          if (hit_cs) begin
            rdat_d[`EVT_BITS:0] = {stack_full_i, sel_src};
            rdat_d[4] = any_pend;
          end
          if (hit_st) begin
            rdat_d[7:0] = stat_q;
          end
          if (hit_mk) begin
            rdat_d[7:0] = mask_q;
          end
        end
      end
      BUS_ACK: begin
        bus_d = BUS_IDLE;
      end
      default: begin
        bus_d = BUS_IDLE;
      end
    endcase
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      bus_q  <= BUS_IDLE;
      ack_q  <= 1'b0;
      err_q  <= 1'b0;
      rdat_q <= 32'h0000_0000;
    end else begin
      bus_q  <= bus_d;
      ack_q  <= ack_d;
      err_q  <= err_d;
      rdat_q <= rdat_d;
    end
  end

  // ============================================================
  // Outputs
  assign wb_rsp_o.ack = ack_q;
  assign wb_rsp_o.err = err_q;
  assign wb_rsp_o.dat = rdat_q;

  assign vec_o.valid = any_pend & ~stack_full_i;
  assign vec_o.src   = sel_src;
  assign wake_o      = |flag_vec;
  assign irq_o       = |(stat_q & mask_q);

endmodule
`default_nettype wire

// *** tb/irq_src_model.sv ***
/* Event source and core stand-in for the interrupt block.
   Assumes bench commands change just after clk_i edges. */
`timescale 1ns/1ns
`default_nettype none
// ============================================================
// Model
module irq_src_model (
  // Clock
  input  wire logic       clk_i,
  // Bench commands
  input  wire logic [7:0] fire_i,
  input  wire logic       take_i,
  // Far side of the block
  output logic [7:0]      event_o,
  output logic            vec_ack_o
);
  logic [7:0] e1_q;
  logic [7:0] e2_q;

  initial begin
    e1_q      = 8'h00;
    e2_q      = 8'h00;
    vec_ack_o = 1'b0;
  end

  // Event held two cycles high, then low
  always @(posedge clk_i) begin
    e1_q      <= fire_i;
    e2_q      <= e1_q;
    vec_ack_o <= take_i;
  end

  assign event_o = e1_q | e2_q;
endmodule
`default_nettype wire

// *** tb/irq_flag_enable_regs_props.sv ***
/* Port checker for the interrupt control block.
   Assumes one clock and a synchronous active-high reset. */
`timescale 1ns/1ns
`default_nettype none
// ============================================================
// Checker
module irq_flag_enable_regs_props
  import irq_flag_enable_pkg::*;
(
  // Clock and reset
  input wire logic                         clk_i,
  input wire logic                         rst_i,
  // Bus and core side
  input wire irq_flag_enable_pkg::wb_req_t  wb_req_i,
  input wire irq_flag_enable_pkg::wb_rsp_t  wb_rsp_o,
  input wire logic [7:0]                   event_i,
  input wire logic                         stack_full_i,
  input wire logic                         vec_ack_i,
  input wire irq_flag_enable_pkg::irq_vec_t vec_o,
  input wire logic                         wake_o
);
  default clocking @(posedge clk_i); endclocking
  default disable iff (rst_i);

  property p_ack_one;
    $rose(wb_req_i.stb) |=> wb_rsp_o.ack || wb_rsp_o.err;
  endproperty
  a_ack_one: assert property (p_ack_one)
    else $error("no bus answer");

  property p_ack_pulse;
    wb_rsp_o.ack |=> !wb_rsp_o.ack;
  endproperty
  a_ack_pulse: assert property (p_ack_pulse)
    else $error("ack too long");

  property p_a7;
    wb_rsp_o.ack && !wb_req_i.we && wb_req_i.adr == 8'h00
      |-> !wb_rsp_o.dat[7];
  endproperty
  a_a7: assert property (p_a7)
    else $error("ctrl a bit 7 set");

  property p_c_zero;
    wb_rsp_o.ack && !wb_req_i.we && wb_req_i.adr == 8'h08
      |-> (wb_rsp_o.dat[7:0] & 8'hee) == 8'h00;
  endproperty
  a_c_zero: assert property (p_c_zero)
    else $error("ctrl c spare bits set");

  property p_stall;
    stack_full_i |-> !vec_o.valid;
  endproperty
  a_stall: assert property (p_stall)
    else $error("vector while stack full");

  property p_take;
    vec_o.valid && vec_ack_i |=> !vec_o.valid;
  endproperty
  a_take: assert property (p_take)
    else $error("vector after take");

  property p_wake;
    $rose(|event_i) |-> ##3 wake_o;
  endproperty
  a_wake: assert property (p_wake)
    else $error("no wake after event");

  property p_valid_wake;
    vec_o.valid |-> wake_o;
  endproperty
  a_valid_wake: assert property (p_valid_wake)
    else $error("vector without flag");
endmodule

bind irq_flag_enable_regs irq_flag_enable_regs_props props_inst (
  .clk_i, .rst_i, .wb_req_i, .wb_rsp_o, .event_i,
  .stack_full_i, .vec_ack_i, .vec_o, .wake_o
);
`default_nettype wire

// *** tb/irq_flag_enable_regs_tb.sv ***
/* Self-checking bench for the interrupt control block.
   Assumes the source model on the far side. */
`timescale 1ns/1ns
`default_nettype none
// ============================================================
// Bench
module irq_flag_enable_regs_tb;
  import irq_flag_enable_pkg::*;
  logic                 clk_i        = 1'b0;
  logic                 rst_i        = 1'b1;
  logic                 stack_full_i = 1'b0;
  logic                 take         = 1'b0;
  logic       [7:0]     fire         = 8'h00;
  wb_req_t              req          = '0;
  wb_rsp_t              rsp;
  irq_vec_t             vec_o;
  logic       [7:0]     event_i;
  logic                 vec_ack_i;
  logic                 wake_o;
  logic                 irq_o;
  logic       [31:0]    q;
  logic                 e;
  int                   n_fail       = 0;
  int                   compares     = 0;
  // Source k: register, enable byte, flag byte
  logic [7:0] fr [8] = '{8'h0, 8'h0, 8'h0, 8'h4, 8'h4, 8'h4, 8'h4, 8'h8};
  logic [7:0] en [8] = '{8'h8, 8'h4, 8'h2, 8'h1, 8'h2, 8'h4, 8'h8, 8'h1};
  logic [7:0] fl [8] = '{8'h40, 8'h20, 8'h10, 8'h10, 8'h20, 8'h40,
                         8'h80, 8'h10};

  always #4 clk_i = ~clk_i;

  irq_flag_enable_regs irq_flag_enable_regs_inst (
    .clk_i, .rst_i, .wb_req_i(req), .wb_rsp_o(rsp), .event_i,
    .stack_full_i, .vec_ack_i, .vec_o, .wake_o, .irq_o
  );
  irq_src_model irq_src_model_inst (
    .clk_i, .fire_i(fire), .take_i(take), .event_o(event_i),
    .vec_ack_o(vec_ack_i)
  );

  task automatic test_done;
    $display("compares %0d mismatches %0d", compares, n_fail);
    if (n_fail == 0 && compares > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask

  task automatic chk(input string s, input logic [31:0] x, g);
    compares++;
    if (g !== x) begin
      n_fail++;
      $display("MISMATCH %s exp %h got %h", s, x, g);
    end
  endtask

  // Classic cycle; ack sampled at a rising edge, request released there
  task automatic bus(input logic w, input logic [7:0] a,
                     input logic [31:0] d);
    int n;
    n = 0;
    @(posedge clk_i);
    req <= '{1'b1, 1'b1, w, a, 4'hf, d};
    do begin
      @(posedge clk_i);
      n++;
    end while (rsp.ack !== 1'b1 && rsp.err !== 1'b1 && n < 20);
    if (rsp.ack !== 1'b1 && rsp.err !== 1'b1) begin
      n_fail++;
      test_done;
    end else begin
      q = rsp.dat;
      e = rsp.err;
      req <= '0;
    end
  endtask

  task automatic rdc(input logic [7:0] a, input logic [31:0] x);
    bus(1'b0, a, 32'h0);
    chk($sformatf("reg %h", a), x, q);
  endtask

  // Outputs read at a rising edge see the settled previous cycle
  task automatic wt(input int n);
    repeat (n + 1) @(posedge clk_i);
  endtask

  task automatic fire_k(input logic [7:0] m);
    fire <= m;
    @(posedge clk_i);
    fire <= 8'h00;
    wt(5);
  endtask

  initial begin
    repeat (10) @(posedge clk_i);
    rst_i <= 1'b0;
    for (int i = 0; i < 3; i++) rdc(8'(4 * i), 32'h0);
    rdc(8'h00, 32'h0);
    bus(1'b1, 8'h00, 32'hff);
    rdc(8'h00, 32'h7f);
    bus(1'b1, 8'h04, 32'hff);
    rdc(8'h04, 32'hff);
    bus(1'b1, 8'h08, 32'hff);
    rdc(8'h08, 32'h11);
    for (int i = 0; i < 3; i++) bus(1'b1, 8'(4 * i), 32'h0);
    // All events with every enable off
    fire_k(8'hff);
    chk("wake", 32'h1, wake_o);
    chk("valid", 32'h0, vec_o.valid);
    rdc(8'h00, 32'h70);
    rdc(8'h04, 32'hf0);
    rdc(8'h08, 32'h10);
    rdc(8'h10, 32'hff);
    bus(1'b1, 8'h14, 32'h04);
    wt(0);
    chk("irq", 32'h1, irq_o);
    bus(1'b1, 8'h14, 32'h00);
    wt(0);
    chk("irq", 32'h0, irq_o);
    bus(1'b1, 8'h10, 32'hff);
    rdc(8'h10, 32'h0);
    for (int i = 0; i < 3; i++) bus(1'b1, 8'(4 * i), 32'h0);
    wt(0);
    chk("wake", 32'h0, wake_o);
    // Each source: master off, stack full, then taken
    for (int k = 0; k < 8; k++) begin
      bus(1'b1, fr[k], {24'h0, en[k]});
      fire_k(8'h01 << k);
      chk("valid", 32'h0, vec_o.valid);
      stack_full_i <= 1'b1;
      bus(1'b1, 8'h00, fr[k] == 8'h0 ? en[k] | fl[k] | 8'h1 : 8'h1);
      wt(0);
      chk("valid", 32'h0, vec_o.valid);
      rdc(8'h0c, 32'h18 | k);
      stack_full_i <= 1'b0;
      wt(0);
      chk("valid", 32'h1, vec_o.valid);
      chk("src", k, vec_o.src);
      rdc(8'h0c, 32'h10 | k);
      take <= 1'b1;
      @(posedge clk_i);
      take <= 1'b0;
      wt(1);
      chk("valid", 32'h0, vec_o.valid);
      rdc(8'h00, fr[k] == 8'h0 ? en[k] : 8'h0);
      rdc(fr[k], {24'h0, en[k]});
      bus(1'b1, fr[k], 32'h0);
    end
    bus(1'b0, 8'h18, 32'h0);
    chk("err", 32'h1, e);
    test_done;
  end
endmodule
`default_nettype wire
